// ### common/pamx_map.vh
`ifndef PAMX_MAP_VH
`define PAMX_MAP_VH
// Register byte addresses on the Wishbone slave
`define PAMX_ADDR_SFC      4'h0
`define PAMX_ADDR_DIR      4'h4
`define PAMX_ADDR_LATCH    4'h8
`define PAMX_ADDR_PINS     4'hC
`define PAMX_ADDR_EXTCTL   4'h0
// Field positions
`define PAMX_BIT_PULLUP_KILL 2
`define PAMX_BIT_EXT_EN      0
// Reset values
`define PAMX_RST_BYTE      8'h00
`define PAMX_RST_BIT       1'b0
`define PAMX_ZERO_WORD     32'h0000_0000
`endif

// ### rtl/pamx_port_a.v
`timescale 1ns/1ps
`default_nettype none
`include "pamx_map.vh"
module pamx_port_a (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        ext_mem_enable_i,
  input  wire        address_phase_active_i,
  input  wire        store_strobe_i,
  input  wire [7:0]  ext_addr_lo_i,
  input  wire [7:0]  ext_wdata_i,
  output reg  [7:0]  ext_rdata_o,
  input  wire [7:0]  pin_i,
  output reg  [7:0]  pin_o,
  output reg  [7:0]  pin_oe_o,
  output reg  [7:0]  pin_pullup_o,
  output reg  [7:0]  input_gate_override_en_o,
  output reg  [7:0]  input_gate_override_val_o,
  output reg         ext_mem_enable_o
);
  reg  [7:0] special_function_control;
  reg  [7:0] direction_bit;
  reg  [7:0] pin_output_latch;
  reg  [7:0] pin_meta;
  reg  [7:0] pin_sampled_value;
  wire       pullup_kill;
  wire       wr_take;
  wire       strobe_or_addr;
  wire [7:0] pullup_override_en;
  wire [7:0] pullup_override_val;
  wire [7:0] drive_override_en;
  wire [7:0] drive_override_val;
  wire [7:0] level_override_en;
  wire [7:0] level_override_val;
  wire [7:0] mux_bus_line;
  reg  [7:0] next_pullup;
  reg  [7:0] next_oe;
  reg  [7:0] next_out;
  reg  [31:0] next_rdata;
  integer    n;

  // Pull-up select for one pin; pullup_kill wins even under override
  function pamx_pullup_bit;
    input ovr_en;
    input ovr_val;
    input dir;
    input latch;
    input kill;
    begin
      if (kill) begin
        pamx_pullup_bit = 1'b0;
      end else if (ovr_en) begin
        pamx_pullup_bit = ovr_val;
      end else begin
        pamx_pullup_bit = ~dir & latch;
      end
    end
  endfunction

  // Driver select; the override ignores the direction bit entirely
  function pamx_drive_bit;
    input ovr_en;
    input ovr_val;
    input dir;
    begin
      if (ovr_en) begin
        pamx_drive_bit = ovr_val;
      end else begin
        pamx_drive_bit = dir;
      end
    end
  endfunction

  // Level select; the override only matters while the driver is on
  function pamx_level_bit;
    input ovr_en;
    input ovr_val;
    input drive_on;
    input latch;
    begin
      if (ovr_en && drive_on) begin
        pamx_level_bit = ovr_val;
      end else begin
        pamx_level_bit = latch;
      end
    end
  endfunction

  // Unmapped offsets read as zero; the pin register is read-only
  function [7:0] pamx_read_byte;
    input [3:0] adr;
    input [7:0] sfc;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pins;
    begin
      case (adr)
        `PAMX_ADDR_SFC: begin
          pamx_read_byte = sfc;
        end
        `PAMX_ADDR_DIR: begin
          pamx_read_byte = dir;
        end
        `PAMX_ADDR_LATCH: begin
          pamx_read_byte = latch;
        end
        `PAMX_ADDR_PINS: begin
          pamx_read_byte = pins;
        end
        default: begin
          pamx_read_byte = `PAMX_RST_BYTE;
        end
      endcase
    end
  endfunction

  // Only the first cycle of a request writes; ack blocks a repeat
  // Byte lane 0 carries the whole register
  assign wr_take = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];

  assign pullup_kill = special_function_control[`PAMX_BIT_PULLUP_KILL];
  // Address-phase flag comes from the memory interface on this clock
  assign strobe_or_addr = store_strobe_i | address_phase_active_i;
  assign pullup_override_en = {8{ext_mem_enable_i}};
  assign drive_override_en  = {8{ext_mem_enable_i}};
  assign level_override_en  = {8{ext_mem_enable_i}};
  assign pullup_override_val = pin_output_latch & ~{8{strobe_or_addr}};
  assign drive_override_val  = {8{strobe_or_addr}};
  assign mux_bus_line = (ext_addr_lo_i & {8{address_phase_active_i}})
                      | (ext_wdata_i & {8{store_strobe_i}});
  assign level_override_val = mux_bus_line;

  always @* begin
    for (n = 0; n < 8; n = n + 1) begin
      next_pullup[n] = pamx_pullup_bit(pullup_override_en[n], pullup_override_val[n],
                                       direction_bit[n], pin_output_latch[n],
                                       pullup_kill);
      next_oe[n] = pamx_drive_bit(drive_override_en[n], drive_override_val[n],
                                  direction_bit[n]);
      next_out[n] = pamx_level_bit(level_override_en[n], level_override_val[n],
                                   next_oe[n], pin_output_latch[n]);
    end
  end

  // Upper bytes read as zero
  always @* begin
    next_rdata = {24'h000000, pamx_read_byte(adr_i, special_function_control, direction_bit,
                                             pin_output_latch, pin_sampled_value)};
  end

  // Pad outputs are registered, so pins lag the strobes by one clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      special_function_control  <= `PAMX_RST_BYTE;
      direction_bit             <= `PAMX_RST_BYTE;
      pin_output_latch          <= `PAMX_RST_BYTE;
      pin_meta                  <= `PAMX_RST_BYTE;
      pin_sampled_value         <= `PAMX_RST_BYTE;
      dat_o                     <= `PAMX_ZERO_WORD;
      ack_o                     <= `PAMX_RST_BIT;
      ext_rdata_o               <= `PAMX_RST_BYTE;
      pin_o                     <= `PAMX_RST_BYTE;
      pin_oe_o                  <= `PAMX_RST_BYTE;
      pin_pullup_o              <= `PAMX_RST_BYTE;
      input_gate_override_en_o  <= `PAMX_RST_BYTE;
      input_gate_override_val_o <= `PAMX_RST_BYTE;
      ext_mem_enable_o          <= `PAMX_RST_BIT;
    end else begin
      pin_meta          <= pin_i;
      pin_sampled_value <= pin_meta;
      ext_rdata_o       <= pin_sampled_value;
      pin_pullup_o      <= next_pullup;
      pin_oe_o          <= next_oe;
      pin_o             <= next_out;
      input_gate_override_en_o  <= `PAMX_RST_BYTE;
      input_gate_override_val_o <= `PAMX_RST_BYTE;
      ext_mem_enable_o  <= ext_mem_enable_i;
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= next_rdata;
      // Writes to the pin register or unmapped offsets fall through
      if (wr_take) begin
        case (adr_i)
          `PAMX_ADDR_SFC: begin
            special_function_control <= dat_i[7:0];
          end
          `PAMX_ADDR_DIR: begin
            direction_bit <= dat_i[7:0];
          end
          `PAMX_ADDR_LATCH: begin
            pin_output_latch <= dat_i[7:0];
          end
          default: begin
            special_function_control <= special_function_control;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/pamx_port_a_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pamx_port_a_asserts (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ext_mem_enable_i,
  input wire logic       ext_mem_enable_o,
  input wire logic       address_phase_active_i,
  input wire logic       store_strobe_i,
  input wire logic [7:0] ext_addr_lo_i,
  input wire logic [7:0] ext_wdata_i,
  input wire logic [7:0] ext_rdata_o,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pin_pullup_o,
  input wire logic [7:0] input_gate_override_en_o,
  input wire logic [7:0] input_gate_override_val_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire act = store_strobe_i | address_phase_active_i;
  drive_val_a: assert property (ext_mem_enable_i |=> pin_oe_o == {8{$past(act)}})
    else $error("drive");
  addr_out_a: assert property (ext_mem_enable_i && address_phase_active_i && !store_strobe_i
    |=> pin_o == $past(ext_addr_lo_i)) else $error("addr");
  data_out_a: assert property (ext_mem_enable_i && store_strobe_i && !address_phase_active_i
    |=> pin_o == $past(ext_wdata_i)) else $error("data");
  pullup_off_a: assert property (ext_mem_enable_i && act |=> pin_pullup_o == 8'h00)
    else $error("pullup");
  gate_zero_a: assert property ({input_gate_override_en_o, input_gate_override_val_o} == 0)
    else $error("gate");
  ext_copy_a: assert property (ext_mem_enable_o == $past(ext_mem_enable_i)) else $error("copy");
  pull_drive_a: assert property ((pin_pullup_o & pin_oe_o) == 8'h00) else $error("clash");
  gpio_hold_a: assert property ((!ext_mem_enable_i && !cyc_i)[*2] |=> $stable(pin_oe_o)
    && $stable(pin_o) && $stable(pin_pullup_o)) else $error("gpio");
  read_path_a: assert property (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
    |-> ext_rdata_o == $past(pin_i, 3)) else $error("rdata");
  cover property (ext_mem_enable_i && address_phase_active_i);
  cover property (ext_mem_enable_i && store_strobe_i);
  cover property (cyc_i && stb_i && !ext_mem_enable_i);
endmodule
bind pamx_port_a pamx_port_a_asserts chk (.*);
`default_nettype wire

// ### testbench/pamx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pamx_mem_model (
  input  wire logic       clk_i, rd_i, latch_i, save_i,
  input  wire logic [7:0] pin_o, pin_oe_o, pin_pullup_o,
  output wire logic [7:0] pin_i
);
  logic [7:0] mem [256];
  logic [7:0] adr;
  logic [7:0] hold = 8'h00;
  logic       latch_q = 0, save_q = 0;
  // Floating bits toggle so a stale value cannot pass
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & (rd_i ? mem[adr] : pin_pullup_o | ~hold));
  always @(posedge clk_i) begin
    hold <= pin_i;
    {latch_q, save_q} <= {latch_i, save_i};
    if (latch_q && latch_i) adr <= pin_i;
    if (save_q && save_i) mem[adr] <= pin_i;
  end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ext_mem_enable_i = 0, rd = 0;
  logic        address_phase_active_i = 0, store_strobe_i = 0, ack_o, ext_mem_enable_o;
  logic [3:0]  adr_i = 0;
  logic [7:0]  ext_addr_lo_i = 8'hA5, ext_wdata_i = 8'h3C, q, ext_rdata_o, pin_i, pin_o, pin_oe_o;
  logic [7:0]  pin_pullup_o, input_gate_override_en_o, input_gate_override_val_o;
  logic [31:0] dat_i = 0, dat_o;
  int          miscompares = 0, samples_checked = 0;
  always #25 clk_i = ~clk_i;
  pamx_port_a dut (.sel_i(4'hF), .*);
  pamx_mem_model mem (.clk_i, .rd_i(rd), .latch_i(address_phase_active_i),
    .save_i(store_strobe_i), .pin_o, .pin_oe_o, .pin_pullup_o, .pin_i);
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i) {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
    do @(posedge clk_i) n++; while (ack_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      miscompares++;
      summarize;
    end
    q = dat_o[7:0];
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task ex(input logic e, input logic ad, input logic st, input logic r, input int n);
    @(posedge clk_i) {ext_mem_enable_i, address_phase_active_i, store_strobe_i, rd} <= {e, ad, st, r};
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    for (int a = 0; a < 12; a += 4) begin
      wb(0, a[3:0], 0);
      `CHK("reset", 8'h00, q)
    end
    wb(1, 4'h0, 8'hFF);
    wb(0, 4'h0, 0);
    `CHK("sfc", 8'hFF, q)
    wb(1, 4'h6, 8'h55);
    wb(0, 4'h6, 0);
    `CHK("unmapped", 8'h00, q)
    wb(1, 4'h0, 8'h00);
    wb(1, 4'h4, 8'h0F);
    wb(1, 4'h8, 8'hAA);
    ex(0, 0, 0, 0, 2);
    `CHK("oe", 8'h0F, pin_oe_o)
    `CHK("out", 8'h0A, pin_o & 8'h0F)
    `CHK("pullup", 8'hA0, pin_pullup_o)
    wb(1, 4'h0, 8'h04);
    ex(0, 0, 0, 0, 2);
    `CHK("kill", 8'h00, pin_pullup_o)
    wb(1, 4'h0, 8'h00);
    ex(1, 1, 0, 0, 1);
    `CHK("addr", 8'hA5, pin_o)
    ex(1, 0, 1, 0, 1);
    `CHK("data", 8'h3C, pin_o)
    ex(1, 0, 0, 1, 4);
    `CHK("rdata", 8'h3C, ext_rdata_o)
    `CHK("idle", 8'hAA, pin_pullup_o)
    summarize;
  end
endmodule
`default_nettype wire
